/* rtl/slp_sector_lock.v */
// Overview of operation
// RULE1: lock read accepts opcode 3Dh or E0h
// RULE2: host sends 24/32-bit sector address after opcode
// RULE3: lock byte driven out on falling clock
// RULE4: extra byte clocks repeat same byte
// RULE5: opcode bits sampled on rising clock
// RULE6: quad mode uses all four lines
// RULE7: sector lock clears addressed lock bit
// RULE8: sector unlock sets addressed lock bit
// RULE9: chip-select rise after address starts operation
// RULE10: busy flag high during sector lock/unlock
// RULE11: global lock clears every lock bit
// RULE12: global unlock sets every lock bit
// RULE13: global ops need select rise after opcode
// RULE14: busy flag high during global ops
// RULE15: pointer set ignored while suspended
// RULE16: pointer set ignored on protection conditions
// RULE17: pointer set needs write enable latch
// RULE18: pointer set needs rise after address
// RULE19: pointer set busy, then clears latch
// RULE20: pointer set failure raises error flag
// RULE21: large device needs wide addressing
// RULE22: wide pointer opcode always 32-bit address
// RULE23: lock commands need scheme select high
// RULE24: volatile lock bit per sector
// RULE25: lock byte zero means protected
`include "slp_defs.vh"

module slp_sector_lock #(
    parameter SECT_AW    = 9,
    parameter SECT_SHIFT = 16
) (
    // clock and reset
    input  wire                      i_core_clk,
    input  wire                      i_rst,
    // serial link
    input  wire                      i_cs_n,
    input  wire                      i_sclk,
    input  wire [3:0]                i_io,
    output reg  [3:0]                o_io,
    output reg  [3:0]                o_io_oe,
    // configuration
    input  wire                      i_addr_wide,
    input  wire                      i_quad_command_mode,
    input  wire                      i_protect_scheme_select,
    input  wire                      i_op_suspended,
    input  wire                      i_nonvolatile_protect_lock,
    input  wire                      i_region_protect_psl,
    input  wire                      i_region_protect_pwd,
    input  wire                      i_region_set_fail,
    input  wire                      i_region_fail_erase,
    // status
    output reg                       o_write_in_progress,
    output reg                       o_write_enable_latch,
    output reg                       o_program_error,
    output reg                       o_erase_error,
    output reg  [31:0]               o_pointer_region_reg,
    output reg  [(1<<SECT_AW)-1:0]   o_sector_lock_bits
);

    localparam NUM_SECT = 1 << SECT_AW;
    localparam integer LOCK_CYC_N =
        (`SLP_LOCK_OP_NS + `SLP_CORE_CLK_NS - 1) / `SLP_CORE_CLK_NS;
    localparam integer PTR_CYC_N =
        (`SLP_PTR_OP_NS + `SLP_CORE_CLK_NS - 1) / `SLP_CORE_CLK_NS;
    // cycle counts cut on purpose to the busy counter width
    localparam [11:0] LOCK_CYC = LOCK_CYC_N[11:0];
    localparam [11:0] PTR_CYC  = PTR_CYC_N[11:0];

    localparam [2:0] ST_CMD  = 3'b001;
    localparam [2:0] ST_DATA = 3'b010;
    localparam [2:0] ST_IGN  = 3'b100;

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    function is_wide_opc;
        input [7:0] opc;
        begin
            is_wide_opc = (opc == `SLP_OPC_LOCK_RD_W) || (opc == `SLP_OPC_LOCK_SET_W) ||
                          (opc == `SLP_OPC_LOCK_CLR_W) || (opc == `SLP_OPC_PTR_SET_W);
        end
    endfunction

    // frame length of a command; zero for opcodes this block does not own
    function [5:0] cmd_end;
        input [7:0] opc;
        input       wide;
        begin
            case (opc)
                `SLP_OPC_WRITE_ENABLE_CMD, `SLP_OPC_ALL_LOCK, `SLP_OPC_ALL_UNLOCK:
                    cmd_end = `SLP_END_OPC;
                `SLP_OPC_LOCK_RD, `SLP_OPC_LOCK_SET, `SLP_OPC_LOCK_CLR, `SLP_OPC_PTR_SET:
                    cmd_end = wide ? `SLP_END_ADDR32 : `SLP_END_ADDR24;
                `SLP_OPC_LOCK_RD_W, `SLP_OPC_LOCK_SET_W, `SLP_OPC_LOCK_CLR_W,
                `SLP_OPC_PTR_SET_W:
                    cmd_end = `SLP_END_ADDR32; // RULE22
                default:
                    cmd_end = `SLP_END_NONE;
            endcase
        end
    endfunction

    function [SECT_AW-1:0] sector_of;
        input [31:0] addr;
        begin
            sector_of = addr[SECT_SHIFT +: SECT_AW];
        end
    endfunction

    // ----------------------------------------
    // link synchronisers
    // ----------------------------------------
    // link pins are asynchronous; the edge detector reads stage two and three only
    reg        cs_s1_reg;
    reg        cs_s2_reg;
    reg        cs_s3_reg;
    reg        sclk_s1_reg;
    reg        sclk_s2_reg;
    reg        sclk_s3_reg;
    reg  [3:0] io_s1_reg;
    reg  [3:0] io_s2_reg;

    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            cs_s1_reg   <= 1'b1;
            cs_s2_reg   <= 1'b1;
            cs_s3_reg   <= 1'b1;
            sclk_s1_reg <= 1'b0;
            sclk_s2_reg <= 1'b0;
            sclk_s3_reg <= 1'b0;
            io_s1_reg   <= 4'h0;
            io_s2_reg   <= 4'h0;
        end
        else
        begin
            cs_s1_reg   <= i_cs_n;
            cs_s2_reg   <= cs_s1_reg;
            cs_s3_reg   <= cs_s2_reg;
            sclk_s1_reg <= i_sclk;
            sclk_s2_reg <= sclk_s1_reg;
            sclk_s3_reg <= sclk_s2_reg;
            io_s1_reg   <= i_io;
            io_s2_reg   <= io_s1_reg;
        end
    end

    wire cs_active = ~cs_s2_reg;
    wire cs_rise   = cs_s2_reg & ~cs_s3_reg;
    wire cs_fall   = ~cs_s2_reg & cs_s3_reg;
    wire sclk_rise = sclk_s2_reg & ~sclk_s3_reg & cs_active;
    wire sclk_fall = ~sclk_s2_reg & sclk_s3_reg & cs_active;

    // ----------------------------------------
    // command shifter
    // ----------------------------------------
    reg  [2:0]  state_reg;
    reg  [5:0]  cnt_reg;
    reg  [39:0] shift_reg;
    reg  [7:0]  opc_reg;
    reg  [31:0] addr_reg;
    reg         over_reg;
    reg  [7:0]  tx_reg;
    reg         quad_reg;

    wire [5:0]  step       = quad_reg ? `SLP_STEP_QUAD : `SLP_STEP_SINGLE;
    wire [5:0]  cnt_next   = cnt_reg + step;
    wire [39:0] shift_next = quad_reg ? {shift_reg[35:0], io_s2_reg} // RULE6
                                      : {shift_reg[38:0], io_s2_reg[0]}; // RULE5
    wire [7:0]  opc_now    = (cnt_next == `SLP_END_OPC) ? shift_next[7:0] : opc_reg;
    wire        wide_now   = is_wide_opc(opc_now) | i_addr_wide;
    wire [5:0]  end_now    = cmd_end(opc_now, i_addr_wide);
    wire [31:0] addr_now   = wide_now ? shift_next[31:0] : {8'h00, shift_next[23:0]};
    wire        is_read    = (opc_now == `SLP_OPC_LOCK_RD) || (opc_now == `SLP_OPC_LOCK_RD_W);
    wire [7:0]  lock_byte  = (o_sector_lock_bits[sector_of(addr_now)] == `SLP_LOCK_BIT_OPEN)
                             ? `SLP_LOCK_BYTE_OPEN : `SLP_LOCK_BYTE_PROT; // RULE25

    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_reg <= ST_CMD;
            cnt_reg   <= 6'h00;
            shift_reg <= 40'h00_0000_0000;
            opc_reg   <= 8'h00;
            addr_reg  <= `SLP_ADDR_RST;
            over_reg  <= 1'b0;
            tx_reg    <= 8'h00;
            quad_reg  <= 1'b0;
            o_io      <= 4'h0;
            o_io_oe   <= `SLP_OE_OFF;
        end
        else if (cs_fall)
        begin
            state_reg <= ST_CMD;
            cnt_reg   <= 6'h00;
            over_reg  <= 1'b0;
            opc_reg   <= 8'h00;
            quad_reg  <= i_quad_command_mode;
        end
        else if (!cs_active)
        begin
            o_io_oe <= `SLP_OE_OFF;
        end
        else if (sclk_rise && state_reg == ST_CMD)
        begin
            shift_reg <= shift_next;
            if (over_reg || (cnt_reg >= `SLP_END_OPC && cnt_reg >= cmd_end(opc_reg, i_addr_wide)))
            begin
                over_reg <= 1'b1; // RULE13 RULE18
            end
            else
            begin
                cnt_reg <= cnt_next;
                opc_reg <= opc_now;
                if (cnt_next == end_now)
                begin
                    addr_reg <= addr_now;
                    if (is_read && i_protect_scheme_select) // RULE1 RULE23
                    begin
                        state_reg <= ST_DATA;
                        tx_reg    <= lock_byte; // RULE2
                    end
                end
                else if (cnt_next == `SLP_END_OPC && end_now == `SLP_END_NONE)
                begin
                    state_reg <= ST_IGN;
                end
            end
        end
        else if (sclk_fall && state_reg == ST_DATA)
        begin
            // rotation repeats the byte on every further eight clocks, or every two clocks in quad mode
            if (quad_reg)
            begin
                o_io    <= tx_reg[7:4]; // RULE6
                tx_reg  <= {tx_reg[3:0], tx_reg[7:4]}; // RULE4
                o_io_oe <= `SLP_OE_QUAD;
            end
            else
            begin
                o_io    <= {2'b00, tx_reg[7], 1'b0}; // RULE3
                tx_reg  <= {tx_reg[6:0], tx_reg[7]}; // RULE4
                o_io_oe <= `SLP_OE_SINGLE;
            end
        end
    end

    // ----------------------------------------
    // command launch on chip-select rise
    // ----------------------------------------
    // only a frame that stopped exactly at its last bit may launch anything
    wire frame_ok = cs_rise && state_reg == ST_CMD && !over_reg &&
                    cnt_reg >= `SLP_END_OPC && cnt_reg == cmd_end(opc_reg, i_addr_wide);
    wire is_set   = (opc_reg == `SLP_OPC_LOCK_SET) || (opc_reg == `SLP_OPC_LOCK_SET_W);
    wire is_clr   = (opc_reg == `SLP_OPC_LOCK_CLR) || (opc_reg == `SLP_OPC_LOCK_CLR_W);
    wire is_glob  = (opc_reg == `SLP_OPC_ALL_LOCK) || (opc_reg == `SLP_OPC_ALL_UNLOCK);
    wire is_ptr   = (opc_reg == `SLP_OPC_PTR_SET) || (opc_reg == `SLP_OPC_PTR_SET_W);
    wire ptr_block = !i_nonvolatile_protect_lock || !i_region_protect_psl ||
                     (!i_region_protect_pwd && !i_nonvolatile_protect_lock); // RULE16
    wire go_lock  = frame_ok && !o_write_in_progress &&
                    (is_set || is_clr || is_glob) && i_protect_scheme_select; // RULE9 RULE13 RULE23
    wire go_ptr   = frame_ok && !o_write_in_progress && is_ptr && !i_op_suspended && // RULE15
                    !ptr_block && o_write_enable_latch; // RULE17 RULE18
    wire go_write_enable_cmd  = frame_ok && !o_write_in_progress && opc_reg == `SLP_OPC_WRITE_ENABLE_CMD;

    // ----------------------------------------
    // self-timed execution
    // ----------------------------------------
    reg  [7:0]  exec_opc_reg;
    reg  [31:0] exec_addr_reg;
    reg  [11:0] busy_cnt_reg;
    wire        done = o_write_in_progress && busy_cnt_reg == 12'h000;

    always @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            exec_opc_reg         <= 8'h00;
            exec_addr_reg        <= `SLP_ADDR_RST;
            busy_cnt_reg         <= 12'h000;
            o_write_in_progress  <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_program_error      <= 1'b0;
            o_erase_error        <= 1'b0;
            o_pointer_region_reg <= `SLP_ADDR_RST;
            o_sector_lock_bits   <= {NUM_SECT{`SLP_LOCK_BIT_OPEN}};
        end
        else if (go_lock || go_ptr)
        begin
            exec_opc_reg        <= opc_reg;
            exec_addr_reg       <= addr_reg;
            o_write_in_progress <= 1'b1; // RULE10 RULE14 RULE19
            busy_cnt_reg        <= (go_ptr ? PTR_CYC : LOCK_CYC) - 12'h001;
            if (go_ptr)
            begin
                o_program_error <= 1'b0;
                o_erase_error   <= 1'b0;
            end
        end
        else if (go_write_enable_cmd)
        begin
            o_write_enable_latch <= 1'b1;
        end
        else if (done)
        begin
            o_write_in_progress <= 1'b0; // RULE10 RULE14
            case (exec_opc_reg)
                `SLP_OPC_LOCK_SET, `SLP_OPC_LOCK_SET_W:
                    o_sector_lock_bits[sector_of(exec_addr_reg)] <= `SLP_LOCK_BIT_PROT; // RULE7 RULE24
                `SLP_OPC_LOCK_CLR, `SLP_OPC_LOCK_CLR_W:
                    o_sector_lock_bits[sector_of(exec_addr_reg)] <= `SLP_LOCK_BIT_OPEN; // RULE8 RULE24
                `SLP_OPC_ALL_LOCK:
                    o_sector_lock_bits <= {NUM_SECT{`SLP_LOCK_BIT_PROT}}; // RULE11
                `SLP_OPC_ALL_UNLOCK:
                    o_sector_lock_bits <= {NUM_SECT{`SLP_LOCK_BIT_OPEN}}; // RULE12
                `SLP_OPC_PTR_SET, `SLP_OPC_PTR_SET_W:
                begin
                    o_write_enable_latch <= 1'b0; // RULE19
                    if (i_region_set_fail)
                    begin
                        o_program_error <= !i_region_fail_erase; // RULE20
                        o_erase_error   <= i_region_fail_erase; // RULE20
                    end
                    else
                    begin
                        o_pointer_region_reg <= exec_addr_reg; // RULE21 RULE22
                    end
                end
                default:
                    o_write_in_progress <= 1'b0;
            endcase
        end
        else if (o_write_in_progress)
        begin
            busy_cnt_reg <= busy_cnt_reg - 12'h001;
        end
    end

endmodule

/* rtl/slp_defs.vh */
`ifndef SLP_DEFS_VH
`define SLP_DEFS_VH

// ----------------------------------------
// command opcodes
// ----------------------------------------
`define SLP_OPC_LOCK_RD      8'h3D
`define SLP_OPC_LOCK_RD_W    8'hE0
`define SLP_OPC_LOCK_SET     8'h36
`define SLP_OPC_LOCK_SET_W   8'hE1
`define SLP_OPC_LOCK_CLR     8'h39
`define SLP_OPC_LOCK_CLR_W   8'hE2
`define SLP_OPC_ALL_LOCK     8'h7E
`define SLP_OPC_ALL_UNLOCK   8'h98
`define SLP_OPC_PTR_SET      8'hFB
`define SLP_OPC_PTR_SET_W    8'hE3
`define SLP_OPC_WRITE_ENABLE_CMD         8'h06

// ----------------------------------------
// frame lengths in bits, opcode included
// ----------------------------------------
`define SLP_END_NONE         6'h00
`define SLP_END_OPC          6'h08
`define SLP_END_ADDR24       6'h20
`define SLP_END_ADDR32       6'h28
`define SLP_STEP_SINGLE      6'h01
`define SLP_STEP_QUAD        6'h04

// ----------------------------------------
// returned lock byte and reset values
// ----------------------------------------
`define SLP_LOCK_BYTE_PROT   8'h00
`define SLP_LOCK_BYTE_OPEN   8'hFF
`define SLP_LOCK_BIT_PROT    1'b0
`define SLP_LOCK_BIT_OPEN    1'b1
`define SLP_ADDR_RST         32'h0000_0000
`define SLP_OE_OFF           4'h0
`define SLP_OE_SINGLE        4'h2
`define SLP_OE_QUAD          4'hF

// ----------------------------------------
// self-timed operation times
// ----------------------------------------
`define SLP_CORE_CLK_NS      8
`define SLP_LOCK_OP_NS       1000
`define SLP_PTR_OP_NS        2000

`endif

/* testbench/slp_sector_lock_asserts.sv */
module slp_sector_lock_asserts #(
    parameter SECT_AW    = 9,
    parameter SECT_SHIFT = 16
) (
    // clock and reset
    input wire                    i_core_clk,
    input wire                    i_rst,
    // serial link
    input wire                    i_cs_n,
    input wire                    i_sclk,
    input wire [3:0]              i_io,
    input wire [3:0]              o_io,
    input wire [3:0]              o_io_oe,
    // configuration
    input wire                    i_addr_wide,
    input wire                    i_quad_command_mode,
    input wire                    i_protect_scheme_select,
    input wire                    i_op_suspended,
    input wire                    i_nonvolatile_protect_lock,
    input wire                    i_region_protect_psl,
    input wire                    i_region_protect_pwd,
    input wire                    i_region_set_fail,
    input wire                    i_region_fail_erase,
    // status
    input wire                    o_write_in_progress,
    input wire                    o_write_enable_latch,
    input wire                    o_program_error,
    input wire                    o_erase_error,
    input wire [31:0]             o_pointer_region_reg,
    input wire [(1<<SECT_AW)-1:0] o_sector_lock_bits
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0] busy_cnt;

    // ------------
    // busy length counter, sampled when busy falls
    // ------------
    always @(posedge i_core_clk)
    begin
        if (i_rst || !o_write_in_progress)
            busy_cnt <= 9'h000;
        else
            busy_cnt <= busy_cnt + 9'h001;
    end

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    oe_release_a: assert property (o_io_oe != 4'h0 |-> !$past(i_cs_n, 5))
        else $error("read driver on after select released");
    oe_mode_a:
        assert property (o_io_oe != 4'h0 |-> o_io_oe == (i_quad_command_mode ? 4'hF : 4'h2))
        else $error("read drive width wrong for mode");
    busy_len_a:
        assert property ($fell(o_write_in_progress) |-> busy_cnt == 9'h07D || busy_cnt == 9'h0FA)
        else $error("busy length wrong");
    busy_start_a:
        assert property ($rose(o_write_in_progress) |-> i_cs_n && $past(i_cs_n, 2))
        else $error("busy rose without select released");
    lock_commit_a:
        assert property (!$stable(o_sector_lock_bits) |->
            $fell(o_write_in_progress) && $past(i_protect_scheme_select))
        else $error("lock bits changed outside completion");
    ptr_commit_a:
        assert property (!$stable(o_pointer_region_reg) |-> $fell(o_write_in_progress)
            && !o_write_enable_latch && !$past(i_op_suspended)
            && $past(i_region_protect_psl) && $past(i_nonvolatile_protect_lock))
        else $error("pointer changed without a legal completion");
    erase_err_a:
        assert property ($rose(o_erase_error) |-> $fell(o_write_in_progress)
            && $past(i_region_set_fail) && $past(i_region_fail_erase))
        else $error("erase error without erase failure");
    prog_err_a:
        assert property ($rose(o_program_error) |-> $fell(o_write_in_progress)
            && $past(i_region_set_fail) && !$past(i_region_fail_erase))
        else $error("program error without program failure");

    cover property ($fell(o_write_in_progress) && !$stable(o_sector_lock_bits));
    cover property (o_io_oe == 4'hF);
    cover property ($rose(o_erase_error));
endmodule

bind slp_sector_lock slp_sector_lock_asserts #(.SECT_AW(SECT_AW), .SECT_SHIFT(SECT_SHIFT))
    chk (.*);

/* testbench/slp_host.sv */
module slp_host (
    // clock
    input  wire         i_core_clk,
    // link
    input  wire  [3:0]  i_io,
    output logic        o_cs_n,
    output logic        o_sclk,
    output logic [3:0]  o_io,
    output logic [15:0] o_rd
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [3:0] val = 4'h0;
    logic [3:0] drv = 4'h0;
    logic       tgl = 1'b0;

    // released lines toggle so a stale bit never passes for data
    always @(posedge i_core_clk)
        tgl <= ~tgl;
    assign o_io = (val & drv) | ({4{tgl}} & ~drv);

    initial
    begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_rd   = 16'h0000;
    end

    // ------------
    // one frame; the clock idles low between frames
    // ------------
    task automatic frame(input logic [39:0] tx, input int ntx, input int nrx, input logic quad);
        int step;
        step = quad ? 4 : 1;
        @(posedge i_core_clk);
        o_cs_n <= 1'b0;
        for (int i = 0; i < ntx + nrx; i += step)
        begin
            drv <= (i >= ntx) ? 4'h0 : (quad ? 4'hF : 4'h1);
            val <= quad ? tx[39:36] : {3'h0, tx[39]};
            tx = tx << step;
            repeat (4) @(posedge i_core_clk);
            o_sclk <= 1'b1;
            repeat (4) @(posedge i_core_clk);
            if (i >= ntx)
                o_rd <= quad ? {o_rd[11:0], i_io} : {o_rd[14:0], i_io[1]};
            o_sclk <= 1'b0;
        end
        repeat (4) @(posedge i_core_clk);
        o_cs_n <= 1'b1;
        drv    <= 4'h0;
        repeat (8) @(posedge i_core_clk);
    endtask
endmodule

/* testbench/slp_sector_lock_tb.sv */
`include "slp_defs.vh"
`define CHK(nm, exp, got) begin samples_checked++; if ((got) !== (exp)) begin err_total++; \
    $display("FAIL %s expected %h seen %h", nm, exp, got); end end

module slp_sector_lock_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic i_core_clk = 1'b0, i_rst = 1'b1, i_addr_wide = 1'b0, i_quad_command_mode = 1'b0;
    logic i_protect_scheme_select = 1'b1, i_op_suspended = 1'b0, i_region_set_fail = 1'b0;
    logic i_nonvolatile_protect_lock = 1'b1, i_region_protect_psl = 1'b1, saw_busy = 1'b0;
    logic i_region_protect_pwd = 1'b1, i_region_fail_erase = 1'b0;
    wire  i_cs_n, i_sclk, o_write_in_progress, o_write_enable_latch, o_program_error;
    wire  o_erase_error;
    wire  [3:0]   i_io, o_io, o_io_oe, host_io;
    wire  [15:0]  rd;
    wire  [31:0]  o_pointer_region_reg;
    wire  [511:0] o_sector_lock_bits;
    int   err_total = 0;
    int   samples_checked = 0;

    always #4 i_core_clk = ~i_core_clk;
    assign i_io = (o_io_oe & o_io) | (~o_io_oe & host_io);
    slp_sector_lock DUT (.*);
    slp_host host (.i_core_clk(i_core_clk), .i_io(i_io), .o_cs_n(i_cs_n), .o_sclk(i_sclk),
                   .o_io(host_io), .o_rd(rd));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // one frame, then a bounded wait for the self-timed part to end
    task automatic cmd(input logic [39:0] tx, input int ntx, input int nrx, input logic q);
        int n;
        n = 0;
        i_quad_command_mode <= q;
        host.frame(tx, ntx, nrx, q);
        saw_busy = o_write_in_progress;
        while (o_write_in_progress !== 1'b0 && n < 400)
        begin
            @(posedge i_core_clk);
            n++;
        end
        `CHK("busy end", 1'b0, o_write_in_progress)
    endtask

    task automatic write_enable_cmd();
        cmd({`SLP_OPC_WRITE_ENABLE_CMD, 32'h0000_0000}, 8, 0, 1'b0);
    endtask

    task automatic t_sector();
        cmd({`SLP_OPC_LOCK_RD, 24'h05_0000, 8'h00}, 32, 16, 1'b0);
        `CHK("open read", 16'hFFFF, rd)
        cmd({`SLP_OPC_LOCK_SET, 24'h05_0000, 8'h00}, 32, 0, 1'b0);
        `CHK("lock busy", 1'b1, saw_busy)
        `CHK("lock bits", 2'b10, o_sector_lock_bits[6:5])
        cmd({`SLP_OPC_LOCK_SET_W, 32'h0007_0000}, 40, 0, 1'b1);
        `CHK("quad lock", 1'b0, o_sector_lock_bits[7])
        cmd({`SLP_OPC_LOCK_RD_W, 32'h0005_0000}, 40, 16, 1'b1);
        `CHK("quad read", {2{`SLP_LOCK_BYTE_PROT}}, rd)
        i_addr_wide <= 1'b1;
        cmd({`SLP_OPC_LOCK_CLR, 32'h0005_0000}, 40, 0, 1'b0);
        cmd({`SLP_OPC_LOCK_CLR_W, 32'h0007_0000}, 40, 0, 1'b0);
        `CHK("clear bits", 3'b111, o_sector_lock_bits[7:5])
        cmd({`SLP_OPC_LOCK_RD, 32'h0007_0000}, 40, 16, 1'b0);
        `CHK("wide read", {2{`SLP_LOCK_BYTE_OPEN}}, rd)
        i_addr_wide <= 1'b0;
    endtask

    task automatic t_global();
        cmd({`SLP_OPC_ALL_LOCK, 32'h0000_0000}, 9, 0, 1'b0);
        `CHK("long frame", 1'b0, saw_busy)
        cmd({`SLP_OPC_ALL_LOCK, 32'h0000_0000}, 8, 0, 1'b0);
        `CHK("global busy", 1'b1, saw_busy)
        `CHK("all locked", {512{1'b0}}, o_sector_lock_bits)
        cmd({`SLP_OPC_ALL_UNLOCK, 32'h0000_0000}, 8, 0, 1'b1);
        `CHK("all open", {512{1'b1}}, o_sector_lock_bits)
    endtask

    task automatic t_scheme();
        i_protect_scheme_select <= 1'b0;
        cmd({`SLP_OPC_LOCK_SET, 24'h02_0000, 8'h00}, 32, 0, 1'b0);
        `CHK("scheme off", 2'b01, {saw_busy, o_sector_lock_bits[2]})
        i_protect_scheme_select <= 1'b1;
    endtask

    task automatic t_pointer();
        cmd({`SLP_OPC_PTR_SET, 24'h12_3400, 8'h00}, 32, 0, 1'b0);
        `CHK("no latch", 1'b0, saw_busy)
        for (int k = 0; k < 4; k++)
        begin
            i_op_suspended <= (k == 0);
            i_nonvolatile_protect_lock <= (k != 1);
            i_region_protect_psl <= (k != 2);
            write_enable_cmd();
            `CHK("latch set", 1'b1, o_write_enable_latch)
            cmd({`SLP_OPC_PTR_SET, 24'h12_3400, 8'h00}, (k == 3) ? 31 : 32, 0, 1'b0);
            `CHK("blocked", 1'b0, saw_busy)
        end
        `CHK("ptr kept", 32'h0000_0000, o_pointer_region_reg)
        i_region_protect_pwd <= 1'b0;
        write_enable_cmd();
        cmd({`SLP_OPC_PTR_SET, 24'h12_3400, 8'h00}, 32, 0, 1'b0);
        `CHK("ptr short", 33'h0_0012_3400, {o_write_enable_latch, o_pointer_region_reg})
        write_enable_cmd();
        cmd({`SLP_OPC_PTR_SET_W, 32'h0123_0000}, 40, 0, 1'b0);
        `CHK("ptr wide", 32'h0123_0000, o_pointer_region_reg)
        i_region_set_fail <= 1'b1;
        for (int k = 1; k >= 0; k--)
        begin
            i_region_fail_erase <= k[0];
            write_enable_cmd();
            cmd({`SLP_OPC_PTR_SET, 24'h00_1000, 8'h00}, 32, 0, 1'b0);
            `CHK("error flags", {k[0], ~k[0]}, {o_erase_error, o_program_error})
        end
        `CHK("ptr on fail", 32'h0123_0000, o_pointer_region_reg)
        i_region_set_fail <= 1'b0;
    endtask

    initial
    begin
        repeat (5) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (6) @(posedge i_core_clk);
        `CHK("reset bits", {512{1'b1}}, o_sector_lock_bits)
        `CHK("reset outs", 40'h00_0000_0000, {o_io_oe, o_write_in_progress, o_write_enable_latch, o_program_error, o_erase_error, o_pointer_region_reg})
        t_sector();
        t_global();
        t_scheme();
        t_pointer();
        give_verdict();
    end

    // about seven times the expected run length
    initial
    begin
        #400_000;
        err_total++;
        give_verdict();
    end
endmodule
